// ### hdl/cbe_top.sv
/*
 Conditional branch evaluator: decodes branch microinstructions, drives the
 logic unit, and updates the microinstruction counter at the end-cycle strobe.
 Assumes rom word, sources and strobe come from logic on clock_i.
*/
// Summary of operation
// - Branch-if-false taken only when all register bits under mask ones are zero.
// - Type 5 asserts equal-detect gate and selects inverted AND.
// - Branch-if-false A operand from B-bus mux; code 011 gives second status register.
// - All-ones output during an equal-detect branch asserts low-half counter load, except branch-if-true on the dummy register.
// - Dummy register gives zero A operand, so branch-if-false is taken.
// - Branch-if-equal-to-mask compares B-field register with A-field constant.
// - High load strobe loads the whole counter from word bits 15:0, low strobe alone the lower byte.
// - Low-half load writes only the lower eight counter bits.
// - Equal-detect gate qualifies the equality output as the taken condition.
// - An option steps the saved address register at end of instruction.
// - Second option steps it after a register instruction using the dummy.
// - Unconditional jump flag asserts both counter load strobes.
// - Untaken branch advances counter to next address at end-cycle strobe.
// - In-page branch replaces low byte with target, keeps high byte.
`timescale 1ns/100ps
module cbe_top (
  // Clock and reset
  input wire logic clock_i,
  input wire logic rst_n_i,
  // Microinstruction and timing
  input wire logic [19:0] rom_word_i,
  input wire logic end_cycle_strobe_i,
  // Register sources
  input wire cbe_pkg::cbe_sources_s sources_i,
  // Saved address register step options
  input wire logic step_option_i,
  input wire logic dummy_step_option_i,
  input wire logic step_down_i,
  // Counter and decode view
  output logic [15:0] microinstruction_counter_o,
  output cbe_pkg::cbe_strobes_s strobes_o,
  output cbe_pkg::cbe_alu_view_s alu_view_o,
  // Saved address register steps
  output logic saved_inc_o,
  output logic saved_dec_o
);
  import cbe_pkg::*;

  logic grp;
  logic [2:0] br_type;
  cbe_nibble_t a_fld;
  cbe_nibble_t b_fld;
  logic [7:0] target;
  logic b_dummy;
  cbe_nibble_t alu_a;
  cbe_nibble_t alu_b;
  cbe_alu_func_e alu_func;
  cbe_nibble_t alu_f;
  logic alu_eq;
  cbe_strobes_s gates;
  cbe_strobes_s strb;
  logic step_req;
  logic [15:0] counter_d, counter_q;
  cbe_strobes_s strobes_d, strobes_q;
  cbe_alu_view_s view_d, view_q;
  logic inc_d, inc_q, dec_d, dec_q;

  assign grp = rom_word_i[CBE_GROUP_BIT];
  assign br_type = rom_word_i[CBE_TYPE_LSB +: 3];
  assign a_fld = rom_word_i[CBE_AFLD_LSB +: 4];
  assign b_fld = rom_word_i[CBE_BFLD_LSB +: 4];
  assign target = {rom_word_i[CBE_YHI_LSB +: 4], rom_word_i[CBE_YLO_LSB +: 4]};
  assign b_dummy = (b_fld == CBE_DUMMY_SEL);

  // High select bit picks the B-bus mux (dummy select 4'hf gives the dummy value), otherwise a file register
  function automatic cbe_nibble_t pick(input cbe_nibble_t sel, input cbe_sources_s src);
    cbe_nibble_t v;
    v = src.file_reg[sel[2:0]];
    if (sel == CBE_DUMMY_SEL) begin
      v = CBE_DUMMY_VALUE;
    end else if (sel[3] && (sel[2:0] == CBE_MUX_SR2)) begin
      v = src.second_status_register;
    end else if (sel[3]) begin
      v = src.mux_src[sel[2:0]];
    end
    return v;
  endfunction

  always_comb begin
    alu_a = pick(b_fld, sources_i);
    alu_b = a_fld;
    alu_func = CBE_FN_NONE;
    gates = '0;
    if (grp) begin
      case (br_type)
        CBE_TYPE_BER: begin
          alu_b = pick(a_fld, sources_i);
          alu_func = CBE_FN_XNOR;
          gates.equal_detect_gate = 1'b1;
        end
        CBE_TYPE_BNR: begin
          alu_b = pick(a_fld, sources_i);
          alu_func = CBE_FN_XNOR;
          gates.not_equal_gate = 1'b1;
        end
        CBE_TYPE_JUMP: begin
          gates.unconditional_jump_flag = 1'b1;
        end
        CBE_TYPE_BT: begin
          alu_func = CBE_FN_OR_NOTB;
          gates.equal_detect_gate = 1'b1;
        end
        CBE_TYPE_BF: begin
          alu_func = CBE_FN_NAND;
          gates.equal_detect_gate = 1'b1;
        end
        CBE_TYPE_BEQ: begin
          alu_func = CBE_FN_XNOR;
          gates.equal_detect_gate = 1'b1;
        end
        default: begin
          alu_func = CBE_FN_NONE;
        end
      endcase
    end
  end

  // Kept apart from the operand decode so no process both feeds and reads the logic unit
  always_comb begin
    strb = gates;
    // Branch-if-true on the dummy register is a no-op by design
    strb.taken = (gates.equal_detect_gate && alu_eq
                  && !(br_type == CBE_TYPE_BT && b_dummy))
                 || (gates.not_equal_gate && !alu_eq);
    strb.counter_low_load = strb.taken || gates.unconditional_jump_flag;
    strb.counter_high_load = gates.unconditional_jump_flag;
  end

  cbe_alu cbe_alu_i (
    .a_i(alu_a),
    .b_i(alu_b),
    .func_i(alu_func),
    .f_o(alu_f),
    .eq_o(alu_eq)
  );

  // Counter group
  always_comb begin
    counter_d = counter_q;
    if (end_cycle_strobe_i) begin
      if (strb.counter_high_load) begin
        counter_d = rom_word_i[15:0];
      end else if (strb.counter_low_load) begin
        counter_d = {counter_q[15:8], target};
      end else begin
        counter_d = counter_q + CBE_COUNTER_STEP;
      end
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      counter_q <= CBE_COUNTER_RST;
    end else begin
      counter_q <= counter_d;
    end
  end

  // Output view group; decode is shown one cycle after it is formed
  always_comb begin
    strobes_d = strb;
    view_d = '{a: alu_a, b: alu_b, func: alu_func, eq: alu_eq};
    step_req = step_option_i
               || (dummy_step_option_i && !grp && b_dummy);
    inc_d = end_cycle_strobe_i && step_req && !step_down_i;
    dec_d = end_cycle_strobe_i && step_req && step_down_i;
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      strobes_q <= '0;
      view_q <= '0;
      inc_q <= 1'b0;
      dec_q <= 1'b0;
    end else begin
      strobes_q <= strobes_d;
      view_q <= view_d;
      inc_q <= inc_d;
      dec_q <= dec_d;
    end
  end

  assign microinstruction_counter_o = counter_q;
  assign strobes_o = strobes_q;
  assign alu_view_o = view_q;
  assign saved_inc_o = inc_q;
  assign saved_dec_o = dec_q;

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);

  logic is_bf, is_beq, cond;
  assign is_bf = grp && (br_type == CBE_TYPE_BF);
  assign is_beq = grp && (br_type == CBE_TYPE_BEQ);
  assign cond = strb.equal_detect_gate || strb.not_equal_gate;

  property p_bf_mask;
    is_bf |-> (strb.taken == ((alu_a & a_fld) == 4'h0));
  endproperty
  a_bf_mask: assert property (p_bf_mask) else $error("bf taken wrong");

  property p_bf_func;
    is_bf |=> strobes_o.equal_detect_gate && alu_view_o.func == CBE_FN_NAND;
  endproperty
  a_bf_func: assert property (p_bf_func) else $error("bf decode wrong");

  property p_sr2;
    is_bf && b_fld == {1'b1, CBE_MUX_SR2} |=> alu_view_o.a == $past(sources_i.second_status_register);
  endproperty
  a_sr2: assert property (p_sr2) else $error("sr2 not routed");

  property p_low_load;
    end_cycle_strobe_i && cond && strb.equal_detect_gate && alu_eq && !b_dummy
      |=> microinstruction_counter_o[7:0] == $past(target);
  endproperty
  a_low_load: assert property (p_low_load) else $error("no in-page load");

  property p_dummy;
    is_bf && b_dummy |-> alu_a == 4'h0 && strb.taken;
  endproperty
  a_dummy: assert property (p_dummy) else $error("dummy bf not taken");

  property p_beq;
    is_beq |-> strb.taken == (pick(b_fld, sources_i) == a_fld);
  endproperty
  a_beq: assert property (p_beq) else $error("beq compare wrong");

  property p_jump;
    end_cycle_strobe_i && strb.unconditional_jump_flag
      |=> microinstruction_counter_o == $past(rom_word_i[15:0]) && strobes_o.counter_high_load;
  endproperty
  a_jump: assert property (p_jump) else $error("jump load wrong");

  property p_keep_high;
    end_cycle_strobe_i && !strb.counter_high_load
      |=> microinstruction_counter_o[15:8] == $past(counter_q[15:8])
          || microinstruction_counter_o == $past(counter_q) + CBE_COUNTER_STEP;
  endproperty
  a_keep_high: assert property (p_keep_high) else $error("high byte disturbed");

  property p_gate;
    strb.equal_detect_gate && !alu_eq |-> !strb.taken;
  endproperty
  a_gate: assert property (p_gate) else $error("taken without equal");

  property p_step;
    end_cycle_strobe_i && step_option_i |=> saved_inc_o != saved_dec_o;
  endproperty
  a_step: assert property (p_step) else $error("no step pulse");

  property p_dstep;
    end_cycle_strobe_i && dummy_step_option_i && !grp && b_dummy |=> saved_inc_o || saved_dec_o;
  endproperty
  a_dstep: assert property (p_dstep) else $error("no dummy step");

  property p_uncond;
    strb.unconditional_jump_flag |-> strb.counter_low_load && strb.counter_high_load;
  endproperty
  a_uncond: assert property (p_uncond) else $error("jump strobes missing");

  property p_seq;
    end_cycle_strobe_i && !strb.counter_low_load
      |=> microinstruction_counter_o == $past(counter_q) + CBE_COUNTER_STEP;
  endproperty
  a_seq: assert property (p_seq) else $error("no sequential advance");

  property p_allones;
    alu_eq == (alu_f == 4'hf);
  endproperty
  a_allones: assert property (p_allones) else $error("equality not all ones");

  c_bf_taken: cover property (end_cycle_strobe_i && is_bf && strb.taken);
  c_beq_taken: cover property (end_cycle_strobe_i && is_beq && strb.taken);
  c_jump: cover property (end_cycle_strobe_i && strb.unconditional_jump_flag);
  c_step: cover property (end_cycle_strobe_i && step_req);
endmodule

// ### common/cbe_pkg.sv
/*
 Constants and carrier types for the conditional branch evaluator.
 Assumes a 20-bit microinstruction word and 4-bit register datapath.
*/
package cbe_pkg;
  // Microinstruction field positions
  localparam int CBE_GROUP_BIT = 19;
  localparam int CBE_TYPE_LSB = 16;
  localparam int CBE_BFLD_LSB = 12;
  localparam int CBE_YHI_LSB = 8;
  localparam int CBE_AFLD_LSB = 4;
  localparam int CBE_YLO_LSB = 0;

  // Branch-type codes in the three-bit type field
  localparam logic [2:0] CBE_TYPE_BER = 3'h0;
  localparam logic [2:0] CBE_TYPE_BNR = 3'h1;
  localparam logic [2:0] CBE_TYPE_JUMP = 3'h3;
  localparam logic [2:0] CBE_TYPE_BT = 3'h4;
  localparam logic [2:0] CBE_TYPE_BF = 3'h5;
  localparam logic [2:0] CBE_TYPE_BEQ = 3'h6;

  // Register select codes
  localparam logic [3:0] CBE_DUMMY_SEL = 4'hf;
  localparam logic [2:0] CBE_MUX_SR2 = 3'h3;
  localparam logic [3:0] CBE_DUMMY_VALUE = 4'h0;

  // Values after reset and counter step
  localparam logic [15:0] CBE_COUNTER_RST = 16'h0000;
  localparam logic [15:0] CBE_COUNTER_STEP = 16'h0001;

  typedef logic [3:0] cbe_nibble_t;

  typedef enum logic [1:0] {
    CBE_FN_NONE,
    CBE_FN_XNOR,
    CBE_FN_OR_NOTB,
    CBE_FN_NAND
  } cbe_alu_func_e;

  typedef struct packed {
    cbe_nibble_t [7:0] file_reg;
    cbe_nibble_t [7:0] mux_src;
    cbe_nibble_t second_status_register;
  } cbe_sources_s;

  typedef struct packed {
    cbe_nibble_t a;
    cbe_nibble_t b;
    cbe_alu_func_e func;
    logic eq;
  } cbe_alu_view_s;

  typedef struct packed {
    logic counter_low_load;
    logic counter_high_load;
    logic equal_detect_gate;
    logic not_equal_gate;
    logic unconditional_jump_flag;
    logic taken;
  } cbe_strobes_s;
endpackage

// ### hdl/cbe_alu.sv
/*
 Four-bit logic unit with all-ones equality output.
 Assumes purely combinational use inside the branch evaluator.
*/
`timescale 1ns/100ps
module cbe_alu (
  // Operands and function
  input wire cbe_pkg::cbe_nibble_t a_i,
  input wire cbe_pkg::cbe_nibble_t b_i,
  input wire cbe_pkg::cbe_alu_func_e func_i,
  // Result
  output cbe_pkg::cbe_nibble_t f_o,
  output logic eq_o
);
  import cbe_pkg::*;

  always_comb begin
    case (func_i)
      CBE_FN_XNOR: f_o = ~(a_i ^ b_i);
      CBE_FN_OR_NOTB: f_o = a_i | ~b_i;
      CBE_FN_NAND: f_o = ~(a_i & b_i);
      default: f_o = 4'h0;
    endcase
  end

  // All ones, not numeric equality of the operands
  assign eq_o = &f_o;
endmodule

// ### tb/cbe_src_model.sv
/*
 Far-side model: microinstruction store and register sources.
 Assumes the bench picks the word by index and sets the register values.
*/
`timescale 1ns/100ps
module cbe_src_model (
  // Selection from the bench
  input wire logic [2:0] idx_i,
  input wire cbe_pkg::cbe_nibble_t sr2_i,
  input wire cbe_pkg::cbe_nibble_t fill_i,
  // Toward the block
  output logic [19:0] rom_word_o,
  output cbe_pkg::cbe_sources_s sources_o
);
  import cbe_pkg::*;
  always_comb begin
    case (idx_i)
      3'h0: rom_word_o = 20'hdb329;
      3'h1: rom_word_o = 20'hdf329;
      3'h2: rom_word_o = 20'hb195b;
      3'h3: rom_word_o = 20'he6603;
      3'h4: rom_word_o = 20'h0f000;
      3'h5: rom_word_o = 20'h02000;
      default: rom_word_o = 20'hf0000;
    endcase
  end
  // Other sources differ from the status value so a wrong select shows
  assign sources_o.file_reg = {8{fill_i}};
  assign sources_o.mux_src = {8{fill_i}};
  assign sources_o.second_status_register = sr2_i;
endmodule

// ### tb/conditional_branch_evaluator_tb.sv
/*
 Self-checking bench for the branch evaluator.
 Assumes one-cycle registered outputs and counter update on the strobe edge.
*/
`timescale 1ns/100ps
module conditional_branch_evaluator_tb;
  import cbe_pkg::*;
  logic clock_i, rst_n_i, strobe, step_opt, dstep_opt, down;
  logic [2:0] idx;
  cbe_nibble_t sr2, fill;
  logic [19:0] rom;
  cbe_sources_s src;
  logic [15:0] cnt, exp_c;
  cbe_strobes_s stb;
  cbe_alu_view_s av;
  logic inc, dec;
  int n_mismatch, total_checks;

  cbe_src_model cbe_src_model_i (.idx_i(idx), .sr2_i(sr2), .fill_i(fill),
    .rom_word_o(rom), .sources_o(src));
  cbe_top cbe_top_i (.clock_i(clock_i), .rst_n_i(rst_n_i), .rom_word_i(rom),
    .end_cycle_strobe_i(strobe), .sources_i(src), .step_option_i(step_opt),
    .dummy_step_option_i(dstep_opt), .step_down_i(down),
    .microinstruction_counter_o(cnt), .strobes_o(stb), .alu_view_o(av),
    .saved_inc_o(inc), .saved_dec_o(dec));

  task automatic chk(input string what, input logic [15:0] e, input logic [15:0] g);
    total_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("BAD %s exp %h got %h", what, e, g);
    end
  endtask
  task automatic chkb(input string what, input logic e, input logic g);
    total_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("BAD %s exp %b got %b", what, e, g);
    end
  endtask
  // Strobe is left as given; the next call sets it, never the same step
  task automatic issue(input logic [2:0] i, input logic s);
    idx = i;
    strobe = s;
    @(posedge clock_i);
    #1;
  endtask
  task automatic t_jump();
    issue(3'h2, 1'b1);
    exp_c = 16'h195b;
    chk("counter", exp_c, cnt);
    chkb("high_load", 1'b1, stb.counter_high_load);
    chkb("low_load", 1'b1, stb.counter_low_load);
    chkb("jump_flag", 1'b1, stb.unconditional_jump_flag);
    $display("test jump done");
  endtask
  task automatic t_bf();
    sr2 = 4'h9;
    fill = 4'hf;
    issue(3'h0, 1'b1);
    exp_c = {exp_c[15:8], 8'h39};
    chk("counter", exp_c, cnt);
    chkb("taken", 1'b1, stb.taken);
    chkb("low_load", 1'b1, stb.counter_low_load);
    chkb("high_load", 1'b0, stb.counter_high_load);
    chkb("eq_gate", 1'b1, stb.equal_detect_gate);
    chkb("ne_gate", 1'b0, stb.not_equal_gate);
    chk("func", 16'(CBE_FN_NAND), 16'(av.func));
    chk("alu_a", 16'h0009, 16'(av.a));
    chk("alu_b", 16'h0002, 16'(av.b));
    chkb("eq", 1'b1, av.eq);
    sr2 = 4'hb;
    issue(3'h0, 1'b1);
    exp_c = exp_c + 16'h0001;
    chk("counter", exp_c, cnt);
    chkb("taken", 1'b0, stb.taken);
    chkb("low_load", 1'b0, stb.counter_low_load);
    chkb("eq", 1'b0, av.eq);
    $display("test bf done");
  endtask
  task automatic t_dummy();
    issue(3'h1, 1'b1);
    exp_c = {exp_c[15:8], 8'h39};
    chk("counter", exp_c, cnt);
    chk("alu_a", 16'h0000, 16'(av.a));
    chkb("taken", 1'b1, stb.taken);
    $display("test dummy done");
  endtask
  task automatic t_beq();
    fill = 4'h0;
    issue(3'h3, 1'b1);
    exp_c = {exp_c[15:8], 8'h63};
    chk("counter", exp_c, cnt);
    chkb("eq_gate", 1'b1, stb.equal_detect_gate);
    chkb("eq", 1'b1, av.eq);
    fill = 4'h5;
    issue(3'h3, 1'b1);
    exp_c = exp_c + 16'h0001;
    chk("counter", exp_c, cnt);
    chkb("taken", 1'b0, stb.taken);
    $display("test beq done");
  endtask
  task automatic t_hold();
    issue(3'h6, 1'b1);
    exp_c = exp_c + 16'h0001;
    chk("counter", exp_c, cnt);
    repeat (3) issue(3'h0, 1'b0);
    chk("counter", exp_c, cnt);
    $display("test hold done");
  endtask
  task automatic t_step();
    step_opt = 1'b1;
    issue(3'h5, 1'b1);
    chkb("inc", 1'b1, inc);
    chkb("dec", 1'b0, dec);
    issue(3'h5, 1'b0);
    chkb("inc", 1'b0, inc);
    step_opt = 1'b0;
    dstep_opt = 1'b1;
    down = 1'b1;
    issue(3'h4, 1'b1);
    chkb("dec", 1'b1, dec);
    issue(3'h5, 1'b1);
    chkb("dec", 1'b0, dec);
    exp_c = exp_c + 16'h0003;
    chk("counter", exp_c, cnt);
    issue(3'h5, 1'b0);
    $display("test step done");
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  initial begin
    clock_i = 1'b0;
    forever #5 clock_i = ~clock_i;
  end
  // Cuts a hang short
  initial begin
    repeat (2000) @(posedge clock_i);
    n_mismatch++;
    report_and_stop();
  end
  initial begin
    rst_n_i = 1'b0;
    strobe = 1'b0;
    step_opt = 1'b0;
    dstep_opt = 1'b0;
    down = 1'b0;
    idx = 3'h0;
    sr2 = 4'h0;
    fill = 4'h0;
    repeat (8) @(posedge clock_i);
    #1;
    chk("reset_counter", CBE_COUNTER_RST, cnt);
    rst_n_i = 1'b1;
    t_jump();
    t_bf();
    t_dummy();
    t_beq();
    t_hold();
    t_step();
    report_and_stop();
  end
endmodule
